// [core/tcs_timer_clock_source_select.sv]
// Purpose: Count source selection, edge qualification and 16-bit count for a timer
// Assumes: Gate permit and register writes come from logic on mclk_in
// Notes: External sources are sampled by two flip-flops before any use

`timescale 1ns/10ps

module tcs_timer_clock_source_select (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // Configuration
  input wire logic [1:0] count_source_select_in,
  input wire logic crystal_osc_enable_in,
  input wire logic ext_sync_enable_in,
  input wire logic [1:0] prescale_in,
  input wire logic counter_on_in,
  input wire logic gate_enable_bit_in,
  input wire logic gate_permit_in,
  // External count sources
  input wire logic external_count_pin_in,
  input wire logic crystal_osc_clk_in,
  input wire logic cap_sense_osc_in,
  // Count byte writes
  input wire logic count_low_byte_wr_in,
  input wire logic count_high_byte_wr_in,
  input wire logic [7:0] count_wr_data_in,
  // Status
  output logic [15:0] count_out,
  output logic overflow_out,
  output logic count_armed_out
);

  tcs_pkg::tcs_state_t st_r;
  tcs_pkg::tcs_state_t st_nxt;

  // ****************************************************************
  // Combinational next state
  // ****************************************************************
  logic [tcs_pkg::TCS_N_SRC-1:0] rise;
  logic [tcs_pkg::TCS_N_SRC-1:0] fall;
  logic instr_tick;
  logic external_sel;
  logic src_rise;
  logic src_fall;
  logic run;
  logic event_ok;
  logic do_write;
  logic rearm;
  logic [tcs_pkg::TCS_PRESC_W-1:0] presc_mask;
  tcs_pkg::tcs_src_kind_t kind;
  int src_idx;

  always_comb begin
    st_nxt = st_r;
    src_idx = tcs_pkg::TCS_IDX_PIN;
    kind = tcs_pkg::TCS_SRC_INSTR;
    event_ok = 1'b0;

    // ****************************************************************
    // Synchroniser chain; edges come from the second stage against its delayed copy
    // ****************************************************************
    st_nxt.sync1 = {cap_sense_osc_in, crystal_osc_clk_in, external_count_pin_in};
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev = st_r.sync2;
    rise = st_r.sync2 & ~st_r.prev;
    fall = ~st_r.sync2 & st_r.prev;

    st_nxt.phase = st_r.phase + tcs_pkg::TCS_PHASE_STEP;
    instr_tick = (st_r.phase == tcs_pkg::TCS_PHASE_LAST);

    // ****************************************************************
    // Source decode
    // ****************************************************************
    case (count_source_select_in)
      tcs_pkg::TCS_SEL_SYS: begin
        kind = tcs_pkg::TCS_SRC_SYS;
      end
      tcs_pkg::TCS_SEL_INSTR: begin
        kind = tcs_pkg::TCS_SRC_INSTR;
      end
      tcs_pkg::TCS_SEL_CAP: begin
        kind = tcs_pkg::TCS_SRC_EXT;
        src_idx = tcs_pkg::TCS_IDX_CAP;
      end
      tcs_pkg::TCS_SEL_EXT: begin
        kind = tcs_pkg::TCS_SRC_EXT;
        src_idx = crystal_osc_enable_in ? tcs_pkg::TCS_IDX_XTAL : tcs_pkg::TCS_IDX_PIN;
      end
      default: begin
        kind = tcs_pkg::TCS_SRC_INSTR;
      end
    endcase
    external_sel = (kind == tcs_pkg::TCS_SRC_EXT);
    src_rise = rise[src_idx];
    src_fall = fall[src_idx];

    // ****************************************************************
    // Enable and gating
    // ****************************************************************
    run = counter_on_in & (~gate_enable_bit_in | gate_permit_in);
    st_nxt.on_d = counter_on_in;
    st_nxt.sel_d = count_source_select_in;
    st_nxt.xtal_d = crystal_osc_enable_in;
    do_write = count_low_byte_wr_in | count_high_byte_wr_in;

    // ****************************************************************
    // Falling-edge arming; a falling edge wins over a same-cycle rearm clear, but counter off wins over both
    // ****************************************************************
    rearm = do_write | (counter_on_in & ~st_r.on_d)
      | (count_source_select_in != st_r.sel_d)
      | (crystal_osc_enable_in != st_r.xtal_d);
    if (!counter_on_in) begin
      st_nxt.armed = 1'b0;
    end else if (external_sel && src_fall) begin
      st_nxt.armed = 1'b1;
    end else if (rearm) begin
      st_nxt.armed = 1'b0;
    end

    // ****************************************************************
    // Count events per source kind
    // ****************************************************************
    case (kind)
      tcs_pkg::TCS_SRC_SYS: begin
        // One per system clock, i.e. four per instruction cycle
        event_ok = 1'b1;
      end
      tcs_pkg::TCS_SRC_INSTR: begin
        event_ok = instr_tick;
      end
      tcs_pkg::TCS_SRC_EXT: begin
        if (ext_sync_enable_in) begin
          // Aligned mode holds a qualified edge until the instruction tick
          // Edges within the same instruction cycle merge into one count
          if (st_r.armed && src_rise && !instr_tick) begin
            st_nxt.pend = 1'b1;
          end else if (instr_tick) begin
            st_nxt.pend = 1'b0;
          end
          event_ok = instr_tick & (st_r.pend | (st_r.armed & src_rise));
        end else begin
          st_nxt.pend = 1'b0;
          event_ok = st_r.armed & src_rise;
        end
      end
      default: begin
        event_ok = 1'b0;
      end
    endcase
    // A held edge must not survive a source or setting change, or it would
    // be counted later without the falling edge that re-arming demands
    if (!run || !external_sel || rearm) begin
      st_nxt.pend = 1'b0;
    end

    // ****************************************************************
    // Prescale ratio
    // ****************************************************************
    case (prescale_in)
      2'h0: presc_mask = tcs_pkg::TCS_PS_MASK_1;
      2'h1: presc_mask = tcs_pkg::TCS_PS_MASK_2;
      2'h2: presc_mask = tcs_pkg::TCS_PS_MASK_4;
      2'h3: presc_mask = tcs_pkg::TCS_PS_MASK_8;
      default: presc_mask = tcs_pkg::TCS_PS_MASK_1;
    endcase

    // ****************************************************************
    // Counter update; a byte write overrides any increment
    // ****************************************************************
    // Wrap to zero falls out of the 16-bit add; the flag marks it one cycle
    st_nxt.ovf = 1'b0;
    if (do_write) begin
      if (count_low_byte_wr_in) begin
        st_nxt.count[tcs_pkg::TCS_BYTE_W-1:0] = count_wr_data_in;
      end
      if (count_high_byte_wr_in) begin
        st_nxt.count[tcs_pkg::TCS_COUNT_W-1:tcs_pkg::TCS_BYTE_W] = count_wr_data_in;
      end
      st_nxt.presc = tcs_pkg::TCS_PRESC_RST;
      st_nxt.pend = 1'b0;
    end else if (run && event_ok) begin
      // Greater-or-equal so a ratio cut mid-run never strands the divider
      if (st_r.presc >= presc_mask) begin
        st_nxt.presc = tcs_pkg::TCS_PRESC_RST;
        st_nxt.count = st_r.count + tcs_pkg::TCS_COUNT_STEP;
        st_nxt.ovf = &st_r.count;
      end else begin
        st_nxt.presc = st_r.presc + tcs_pkg::TCS_PRESC_STEP;
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r <= tcs_pkg::TCS_STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs, straight from the state register
  // ****************************************************************
  assign count_out = st_r.count;
  assign overflow_out = st_r.ovf;
  assign count_armed_out = st_r.armed;

endmodule

// [core/tcs_pkg.sv]
// Purpose: Shared constants and state type for the timer clock source select block
// Assumes: mclk_in is the system clock (Fosc) at 250 MHz
// Notes: Select codes and prescale masks are fixed by the count-source encoding

// ****************************************************************
// Constants
// ****************************************************************
package tcs_pkg;

  // Count source select codes
  localparam logic [1:0] TCS_SEL_INSTR = 2'h0;
  localparam logic [1:0] TCS_SEL_SYS = 2'h1;
  localparam logic [1:0] TCS_SEL_EXT = 2'h2;
  localparam logic [1:0] TCS_SEL_CAP = 2'h3;

  // Widths
  localparam int TCS_COUNT_W = 16;
  localparam int TCS_BYTE_W = 8;
  localparam int TCS_N_SRC = 3;
  localparam int TCS_PRESC_W = 3;

  // Index of each external source in the sampled vector
  localparam int TCS_IDX_PIN = 0;
  localparam int TCS_IDX_XTAL = 1;
  localparam int TCS_IDX_CAP = 2;

  // Instruction cycle is four system clocks; last phase carries the tick
  localparam logic [1:0] TCS_PHASE_STEP = 2'h1;
  localparam logic [1:0] TCS_PHASE_LAST = 2'h3;

  // Prescale terminal values for ratios 1, 2, 4 and 8
  localparam logic [2:0] TCS_PS_MASK_1 = 3'h0;
  localparam logic [2:0] TCS_PS_MASK_2 = 3'h1;
  localparam logic [2:0] TCS_PS_MASK_4 = 3'h3;
  localparam logic [2:0] TCS_PS_MASK_8 = 3'h7;
  localparam logic [2:0] TCS_PRESC_STEP = 3'h1;
  localparam logic [2:0] TCS_PRESC_RST = 3'h0;

  localparam logic [15:0] TCS_COUNT_RST = 16'h0000;
  localparam logic [15:0] TCS_COUNT_STEP = 16'h0001;

  // Nominal crystal frequency, informational only
  localparam int TCS_XTAL_HZ = 32768;
  localparam int TCS_MCLK_HZ = 250000000;

  typedef enum logic [1:0] {
    TCS_SRC_SYS,
    TCS_SRC_INSTR,
    TCS_SRC_EXT
  } tcs_src_kind_t;

  typedef struct packed {
    logic [TCS_N_SRC-1:0] sync1;
    logic [TCS_N_SRC-1:0] sync2;
    logic [TCS_N_SRC-1:0] prev;
    logic [1:0] phase;
    logic [TCS_PRESC_W-1:0] presc;
    logic armed;
    logic on_d;
    logic pend;
    logic [1:0] sel_d;
    logic xtal_d;
    logic [TCS_COUNT_W-1:0] count;
    logic ovf;
  } tcs_state_t;

  localparam tcs_state_t TCS_STATE_RST = '0;

endpackage

// [bench/tcs_asserts.sv]
// Purpose: Port checks for the timer clock source select block
// Assumes: One clock domain, reset active low
// Notes: Sees only the top module ports
`timescale 1ns/10ps
module tcs_chk (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // Configuration
  input wire logic [1:0] count_source_select_in,
  input wire logic ext_sync_enable_in,
  input wire logic [1:0] prescale_in,
  input wire logic counter_on_in,
  input wire logic gate_enable_bit_in,
  input wire logic gate_permit_in,
  // Writes
  input wire logic count_low_byte_wr_in,
  input wire logic count_high_byte_wr_in,
  input wire logic [7:0] count_wr_data_in,
  // Status
  input wire logic [15:0] count_out,
  input wire logic overflow_out,
  input wire logic count_armed_out
);
  logic wr;
  assign wr = count_low_byte_wr_in | count_high_byte_wr_in;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  AST_OFF_HOLD: assert property (!counter_on_in && !wr |=> $stable(count_out))
    else $error("count moved while off");
  AST_GATE_HOLD: assert property (gate_enable_bit_in && !gate_permit_in && !wr
    |=> $stable(count_out)) else $error("count moved while gated");
  AST_LOW_WR: assert property (count_low_byte_wr_in
    |=> count_out[7:0] == $past(count_wr_data_in)) else $error("low byte write lost");
  AST_HIGH_WR: assert property (count_high_byte_wr_in
    |=> count_out[15:8] == $past(count_wr_data_in)) else $error("high byte write lost");
  AST_SYS_INC: assert property (counter_on_in && !gate_enable_bit_in && !wr
    && count_source_select_in == 2'h1 && prescale_in == 2'h0
    |=> count_out == $past(count_out) + 16'h0001) else $error("system clock step wrong");
  AST_WRAP: assert property (overflow_out
    |-> count_out == 16'h0000 && $past(count_out) == 16'hffff) else $error("bad wrap");
  AST_OVF_PULSE: assert property (overflow_out |=> !overflow_out)
    else $error("overflow longer than one cycle");
  AST_DISARMED: assert property (count_source_select_in == 2'h2 && !ext_sync_enable_in
    && !count_armed_out && !wr |=> $stable(count_out)) else $error("counted while disarmed");
endmodule
bind tcs_timer_clock_source_select tcs_chk u_chk (.mclk_in, .arst_n_in,
  .count_source_select_in, .ext_sync_enable_in, .prescale_in, .counter_on_in,
  .gate_enable_bit_in, .gate_permit_in, .count_low_byte_wr_in, .count_high_byte_wr_in,
  .count_wr_data_in, .count_out, .overflow_out, .count_armed_out);

// [bench/tcs_src_model.sv]
// Purpose: External count sources: pin, crystal oscillator, cap-sense oscillator
// Assumes: Lines are always driven, idle low
// Notes: Pulses are slower than one instruction cycle so none collapse
`timescale 1ns/10ps
module tcs_src_model (
  // Clock
  input wire logic mclk_in,
  // Count lines
  output logic pin_out,
  output logic xtal_out,
  output logic cap_out
);
  logic [2:0] lines = 3'h0;
  assign {cap_out, xtal_out, pin_out} = lines;
  // Rise then fall, four clocks each; the first rise is never preceded by a fall
  task automatic pulse(input int idx, input int n);
    repeat (n) begin
      @(negedge mclk_in) lines[idx] = 1'b1;
      repeat (4) @(negedge mclk_in);
      lines[idx] = 1'b0;
      repeat (3) @(negedge mclk_in);
    end
  endtask
endmodule

// [bench/tcs_timer_clock_source_select_test.sv]
// Purpose: Self-checking bench for the timer clock source select block
// Assumes: 250 MHz clock, inputs driven on the falling edge
// Notes: Rates are judged over whole windows so phase alignment cannot matter
`timescale 1ns/10ps
module tcs_timer_clock_source_select_test;
  logic clk = 1'b0, rst_n = 1'b0, xo = 1'b0, on = 1'b0, ge = 1'b0, gp = 1'b0;
  logic sy = 1'b0, wl = 1'b0, wh = 1'b0, ovf, arm, pin, xt, cap;
  logic [1:0] sel = 2'h0, ps = 2'h0;
  logic [7:0] wd = 8'h00;
  logic [15:0] cnt, c0;
  int err_total = 0, checked = 0;
  tcs_timer_clock_source_select dut (.mclk_in(clk), .arst_n_in(rst_n),
    .count_source_select_in(sel), .crystal_osc_enable_in(xo), .ext_sync_enable_in(sy),
    .prescale_in(ps), .counter_on_in(on), .gate_enable_bit_in(ge), .gate_permit_in(gp),
    .external_count_pin_in(pin), .crystal_osc_clk_in(xt), .cap_sense_osc_in(cap),
    .count_low_byte_wr_in(wl), .count_high_byte_wr_in(wh), .count_wr_data_in(wd),
    .count_out(cnt), .overflow_out(ovf), .count_armed_out(arm));
  tcs_src_model src (.mclk_in(clk), .pin_out(pin), .xtal_out(xt), .cap_out(cap));
  initial forever #2 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic lo, input logic hi, input logic [7:0] d);
    wl = lo;
    wh = hi;
    wd = d;
    cyc(1);
    wl = 1'b0;
    wh = 1'b0;
    cyc(1);
  endtask
  task automatic t_write;
    wr(1'b1, 1'b0, 8'h34);
    wr(1'b0, 1'b1, 8'h12);
    chk(cnt, 16'h1234);
    wr(1'b1, 1'b1, 8'ha5);
    cyc(5);
    chk(cnt, 16'ha5a5);
    $display("t_write done");
  endtask
  task automatic t_sys;
    sel = 2'h1;
    wr(1'b1, 1'b1, 8'hff);
    wr(1'b1, 1'b0, 8'hfe);
    on = 1'b1;
    cyc(2);
    chk(cnt, 16'h0000);
    chk({15'h0, ovf}, 16'h0001);
    cyc(1);
    chk(cnt, 16'h0001);
    chk({15'h0, ovf}, 16'h0000);
    ge = 1'b1;
    c0 = cnt;
    cyc(9);
    chk(cnt, c0);
    gp = 1'b1;
    cyc(8);
    chk(cnt, c0 + 16'h0008);
    $display("t_sys done");
  endtask
  task automatic t_instr;
    ge = 1'b0;
    sel = 2'h0;
    for (int p = 0; p < 4; p++) begin
      ps = p[1:0];
      cyc(40);
      c0 = cnt;
      cyc(64);
      chk(cnt - c0, 16'h0010 >> p);
    end
    $display("t_instr done");
  endtask
  task automatic t_ext;
    int k;
    ps = 2'h0;
    for (int s = 0; s < 4; s++) begin
      k = (s == 3) ? 2 : s;
      sel = (k == 2) ? 2'h3 : 2'h2;
      xo = (k == 1);
      sy = (s == 3);
      wr(1'b1, 1'b1, 8'h00);
      chk({15'h0, arm}, 16'h0000);
      src.pulse((k + 1) % 3, 3);
      src.pulse(k, 4);
      cyc(12);
      chk(cnt, 16'h0003);
      chk({15'h0, arm}, 16'h0001);
    end
    $display("t_ext done");
  endtask
  task automatic test_done;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #20000;
    err_total++;
    test_done();
  end
  initial begin
    cyc(12);
    rst_n = 1'b1;
    cyc(1);
    t_write();
    t_sys();
    t_instr();
    t_ext();
    test_done();
  end
endmodule
